// >>> jbsp_defs.vh
// constants for the boundary-scan test port: instruction codes, tap states,
// identification word layout and boundary chain length.
// assumes inclusion by the design file jbsp_port.v and by the test bench.
`ifndef JBSP_DEFS_VH
`define JBSP_DEFS_VH

// ----------------------------------------
// instruction register
// ----------------------------------------
`define JBSP_IR_W 3
`define JBSP_OP_EXT 3'h0
`define JBSP_OP_IDENT 3'h1
`define JBSP_OP_SAMPLE 3'h2
`define JBSP_OP_CLAMP 3'h3
`define JBSP_OP_FLOAT 3'h4
`define JBSP_OP_MFG 3'h5
`define JBSP_OP_PASS 3'h7
`define JBSP_IR_CAPT 3'h1

// ----------------------------------------
// tap controller states
// ----------------------------------------
`define JBSP_ST_W 4
`define JBSP_ST_RESET 4'hF
`define JBSP_ST_IDLE 4'hC
`define JBSP_ST_SEL_DR 4'h7
`define JBSP_ST_CAP_DR 4'h6
`define JBSP_ST_SH_DR 4'h2
`define JBSP_ST_EX1_DR 4'h1
`define JBSP_ST_PA_DR 4'h3
`define JBSP_ST_EX2_DR 4'h0
`define JBSP_ST_UPD_DR 4'h5
`define JBSP_ST_SEL_IR 4'h4
`define JBSP_ST_CAP_IR 4'hE
`define JBSP_ST_SH_IR 4'hA
`define JBSP_ST_EX1_IR 4'h9
`define JBSP_ST_PA_IR 4'hB
`define JBSP_ST_EX2_IR 4'h8
`define JBSP_ST_UPD_IR 4'hD

// ----------------------------------------
// identification word and boundary chain
// ----------------------------------------
`define JBSP_ID_W 32
`define JBSP_ID_FIXED 1'b1
`define JBSP_MFG_W 11
`define JBSP_PART_W 16
`define JBSP_VER_W 4
`define JBSP_BS_IN 8
`define JBSP_BS_OUT 8
`define JBSP_BS_W 16

`endif

// >>> jbsp_port.v
// boundary-scan test access port: tap controller, instruction register,
// identification word, one-bit pass stage and boundary chain.
// assumes tck, tms, tdi come from a tester off the clk domain; core pins are
// synchronous to clk.
`timescale 1ns/10ps
`include "jbsp_defs.vh"

module jbsp_port #(
  parameter [10:0] MFG_CODE = 11'h2AB,  // arbitrary value
  parameter [15:0] PART_CODE = 16'h1234,  // arbitrary value
  parameter [3:0] VER_CODE = 4'h1  // arbitrary value
) (
  input wire clk,  // system clock, 10 MHz
  input wire reset,  // synchronous, active high
  input wire tck,  // test clock pin
  input wire tms,  // mode select pin
  input wire tdi,  // test data in pin
  output reg tdo_r,  // test data out level
  output reg tdo_oe_r,  // high while tdo is driven
  input wire [7:0] pin_in,  // system input pins
  output reg [7:0] core_in_r,  // inputs handed to core
  input wire [7:0] core_out,  // core output values
  input wire [7:0] core_oe,  // core output enables
  output reg [7:0] pin_out_r,  // system output pin levels
  output reg [7:0] pin_oe_r,  // system output pin enables
  output reg [2:0] ir_r  // current instruction, for observation
);

  // ----------------------------------------
  // synchronisers and tck edge detection
  // ----------------------------------------
  reg tck_m_r, tck_s_r, tck_d_r;
  reg tms_m_r, tms_s_r;
  reg tdi_m_r, tdi_s_r;
  wire tck_rise;
  wire tck_fall;

  // two flops on every tester pin, a third on tck for edge detection
  always @(posedge clk)
  begin
    if (reset)
    begin
      tck_m_r <= 1'b0;
      tck_s_r <= 1'b0;
      tck_d_r <= 1'b0;
      tms_m_r <= 1'b1;
      tms_s_r <= 1'b1;
      tdi_m_r <= 1'b0;
      tdi_s_r <= 1'b0;
    end
    else
    begin
      tck_m_r <= tck;
      tck_s_r <= tck_m_r;
      tck_d_r <= tck_s_r;
      tms_m_r <= tms;
      tms_s_r <= tms_m_r;
      tdi_m_r <= tdi;
      tdi_s_r <= tdi_m_r;
    end
  end

  assign tck_rise = tck_s_r & ~tck_d_r;
  assign tck_fall = ~tck_s_r & tck_d_r;

  // ----------------------------------------
  // tap controller
  // ----------------------------------------
  reg [3:0] st_r;
  reg [3:0] st_nxt;

  // next state from tms
  always @*
  begin
    case (st_r)
      `JBSP_ST_RESET: st_nxt = tms_s_r ? `JBSP_ST_RESET : `JBSP_ST_IDLE;
      `JBSP_ST_IDLE: st_nxt = tms_s_r ? `JBSP_ST_SEL_DR : `JBSP_ST_IDLE;
      `JBSP_ST_SEL_DR: st_nxt = tms_s_r ? `JBSP_ST_SEL_IR : `JBSP_ST_CAP_DR;
      `JBSP_ST_CAP_DR: st_nxt = tms_s_r ? `JBSP_ST_EX1_DR : `JBSP_ST_SH_DR;
      `JBSP_ST_SH_DR: st_nxt = tms_s_r ? `JBSP_ST_EX1_DR : `JBSP_ST_SH_DR;
      `JBSP_ST_EX1_DR: st_nxt = tms_s_r ? `JBSP_ST_UPD_DR : `JBSP_ST_PA_DR;
      `JBSP_ST_PA_DR: st_nxt = tms_s_r ? `JBSP_ST_EX2_DR : `JBSP_ST_PA_DR;
      `JBSP_ST_EX2_DR: st_nxt = tms_s_r ? `JBSP_ST_UPD_DR : `JBSP_ST_SH_DR;
      `JBSP_ST_UPD_DR: st_nxt = tms_s_r ? `JBSP_ST_SEL_DR : `JBSP_ST_IDLE;
      `JBSP_ST_SEL_IR: st_nxt = tms_s_r ? `JBSP_ST_RESET : `JBSP_ST_CAP_IR;
      `JBSP_ST_CAP_IR: st_nxt = tms_s_r ? `JBSP_ST_EX1_IR : `JBSP_ST_SH_IR;
      `JBSP_ST_SH_IR: st_nxt = tms_s_r ? `JBSP_ST_EX1_IR : `JBSP_ST_SH_IR;
      `JBSP_ST_EX1_IR: st_nxt = tms_s_r ? `JBSP_ST_UPD_IR : `JBSP_ST_PA_IR;
      `JBSP_ST_PA_IR: st_nxt = tms_s_r ? `JBSP_ST_EX2_IR : `JBSP_ST_PA_IR;
      `JBSP_ST_EX2_IR: st_nxt = tms_s_r ? `JBSP_ST_UPD_IR : `JBSP_ST_SH_IR;
      `JBSP_ST_UPD_IR: st_nxt = tms_s_r ? `JBSP_ST_SEL_DR : `JBSP_ST_IDLE;
      default: st_nxt = `JBSP_ST_RESET;
    endcase
  end

  // state advances on each rising tck
  always @(posedge clk)
  begin
    if (reset)
      st_r <= `JBSP_ST_RESET;
    else if (tck_rise)
      st_r <= st_nxt;
  end

  // ----------------------------------------
  // instruction register and decode
  // ----------------------------------------
  reg [2:0] ir_sh_r;
  wire sel_bs;
  wire sel_id;
  wire test_mode;

  // ir shifts lsb first toward tdo, updates on update-ir
  always @(posedge clk)
  begin
    if (reset)
    begin
      ir_sh_r <= `JBSP_OP_IDENT;
      ir_r <= `JBSP_OP_IDENT;
    end
    else if (tck_rise)
    begin
      if (st_nxt == `JBSP_ST_RESET)
        ir_r <= `JBSP_OP_IDENT;
      else if (st_r == `JBSP_ST_CAP_IR)
        ir_sh_r <= `JBSP_IR_CAPT;
      else if (st_r == `JBSP_ST_SH_IR)
        ir_sh_r <= {tdi_s_r, ir_sh_r[2:1]};
      else if (st_r == `JBSP_ST_UPD_IR)
        ir_r <= ir_sh_r;
    end
  end

  // boundary chain for ext test and sample; id for ident; else pass stage
  assign sel_bs = (ir_r == `JBSP_OP_EXT) | (ir_r == `JBSP_OP_SAMPLE);
  assign sel_id = (ir_r == `JBSP_OP_IDENT);
  // reserved and other unknown codes fall to the pass stage
  assign test_mode = (ir_r == `JBSP_OP_EXT) | (ir_r == `JBSP_OP_CLAMP);

  // ----------------------------------------
  // data registers
  // ----------------------------------------
  reg [31:0] id_sh_r;
  reg pass_r;
  reg [15:0] bs_sh_r;
  reg [15:0] bs_upd_r;
  wire [31:0] id_word;

  assign id_word = {VER_CODE, PART_CODE, MFG_CODE, `JBSP_ID_FIXED};

  // capture, shift and update of the selected data register
  always @(posedge clk)
  begin
    if (reset)
    begin
      id_sh_r <= 32'h0;
      pass_r <= 1'b0;
      bs_sh_r <= 16'h0;
      bs_upd_r <= 16'h0;
    end
    else if (tck_rise)
    begin
      if (st_r == `JBSP_ST_CAP_DR)
      begin
        id_sh_r <= id_word;
        pass_r <= 1'b0;
        if (sel_bs)
          bs_sh_r <= {core_out, pin_in};
      end
      else if (st_r == `JBSP_ST_SH_DR)
      begin
        if (sel_id)
          id_sh_r <= {tdi_s_r, id_sh_r[31:1]};
        else if (sel_bs)
          bs_sh_r <= {tdi_s_r, bs_sh_r[15:1]};
        else
          pass_r <= tdi_s_r;
      end
      else if (st_r == `JBSP_ST_UPD_DR && sel_bs)
        bs_upd_r <= bs_sh_r;
    end
  end

  // ----------------------------------------
  // tdo: falling tck, driven only in shift states
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (reset)
    begin
      tdo_r <= 1'b0;
      tdo_oe_r <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo_oe_r <= (st_r == `JBSP_ST_SH_DR) | (st_r == `JBSP_ST_SH_IR);
      if (st_r == `JBSP_ST_SH_IR)
        tdo_r <= ir_sh_r[0];
      else if (sel_id)
        tdo_r <= id_sh_r[0];
      else if (sel_bs)
        tdo_r <= bs_sh_r[0];
      else
        tdo_r <= pass_r;
    end
  end

  // ----------------------------------------
  // pin multiplexing
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (reset)
    begin
      core_in_r <= 8'h00;
      pin_out_r <= 8'h00;
      pin_oe_r <= 8'h00;
    end
    else
    begin
      core_in_r <= pin_in;
      if (ir_r == `JBSP_OP_FLOAT)
      begin
        pin_out_r <= 8'h00;
        pin_oe_r <= 8'h00;
      end
      else if (test_mode)
      begin
        pin_out_r <= bs_upd_r[15:8];
        pin_oe_r <= 8'hFF;
      end
      else
      begin
        pin_out_r <= core_out;
        pin_oe_r <= core_oe;
      end
    end
  end

endmodule // jbsp_port

// >>> jbsp_port_properties.sv
// checker for the scan port: instruction reset, pin paths, scan out timing
// assumes binding to jbsp_port; sees its ports only
`timescale 1ns/10ps
module jbsp_port_props (
  input wire clk, // system clock
  input wire reset, // sync reset
  input wire tck, // test clock pin
  input wire tdo_r, // scan out level
  input wire tdo_oe_r, // scan out enable
  input wire [7:0] pin_in, // input pins
  input wire [7:0] core_in_r, // inputs to core
  input wire [7:0] core_out, // core values
  input wire [7:0] core_oe, // core enables
  input wire [7:0] pin_out_r, // pin levels
  input wire [7:0] pin_oe_r, // pin enables
  input wire [2:0] ir_r // instruction
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_reset_ident: assert property (disable iff (1'b0) reset |=> ir_r == 3'h1)
    else $error("instruction not identification after reset");
  a_reset_tdo_off: assert property (disable iff (1'b0) reset |=> !tdo_oe_r)
    else $error("scan out driven after reset");
  a_core_pass: assert property (1'b1 |=> core_in_r == $past(pin_in))
    else $error("input pins not passed to core");
  a_float_off: assert property (ir_r == 3'h4 [*3] |-> pin_oe_r == 8'h00)
    else $error("pins driven under float");
  a_sample_pass: assert property ((ir_r == 3'h2) [*3] |-> pin_out_r == $past(core_out) &&
    pin_oe_r == $past(core_oe))
    else $error("core outputs not passed under sample");
  a_clamp_hold: assert property ((ir_r == 3'h3) [*4] |-> $stable(pin_out_r) &&
    pin_oe_r == 8'hFF)
    else $error("pins moved under clamp");
  a_ext_drive: assert property (ir_r == 3'h0 [*4] |-> pin_oe_r == 8'hFF)
    else $error("pins not driven under external test");
  a_tdo_on_fall: assert property ($changed(tdo_r) && !$past(reset) |-> !tck)
    else $error("scan out changed while test clock high");
endmodule // jbsp_port_props

bind jbsp_port jbsp_port_props i_props (.clk(clk), .reset(reset), .tck(tck), .tdo_r(tdo_r),
  .tdo_oe_r(tdo_oe_r), .pin_in(pin_in), .core_in_r(core_in_r), .core_out(core_out),
  .core_oe(core_oe), .pin_out_r(pin_out_r), .pin_oe_r(pin_oe_r), .ir_r(ir_r));

// >>> jbsp_tester.sv
// tester model: drives tck, tms, tdi and samples tdo
// assumes clk at 100 ns; tck runs only inside frames, 800 ns period
`timescale 1ns/10ps
module jbsp_tester (
  input wire clk, // bench clock
  input wire tdo, // scan out from device
  output reg tck, // test clock
  output reg tms, // mode select
  output reg tdi // test data
);
  reg [31:0] sh; // shifted out bits, newest on top
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one tck period: fall, sample tdo late in low phase, rise
  task step(input m, input b, output q);
    begin
      @(posedge clk);
      tck <= 1'b0;
      tms <= m;
      tdi <= b;
      repeat (4) @(posedge clk);
      q = tdo;
      tck <= 1'b1;
      repeat (3) @(posedge clk);
    end
  endtask
  // idle to shift, n bits lsb first, update, back to idle
  task scan(input integer n, input s, input [31:0] d);
    integer j;
    reg q;
    begin
      step(1'b1, 1'b0, q);
      if (s)
        step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
      step(1'b0, 1'b0, q);
      for (j = 0; j < n; j = j + 1)
      begin
        step(j == n - 1, d[j], q);
        sh = {q, sh[31:1]};
      end
      step(1'b1, 1'b0, q);
      step(1'b0, ~d[n-1], q);
      // tck stands high while pin outputs follow the new register values
      repeat (2) @(posedge clk);
    end
  endtask
  // reserved code is never sent
  task ir(input [2:0] c, output [2:0] o);
    begin
      scan(3, 1'b1, {29'h0, (c == 3'h5) ? 3'h7 : c});
      o = sh[31:29];
    end
  endtask
  task dr(input [31:0] d, output [31:0] o);
    begin
      scan(32, 1'b0, d);
      o = sh;
    end
  endtask
  // five rises with tms high, then idle
  task rst;
    integer j;
    reg q;
    begin
      for (j = 0; j < 5; j = j + 1)
        step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
    end
  endtask
endmodule // jbsp_tester

// >>> test_jbsp_port.sv
// self-checking bench for the scan port
// assumes tester model jbsp_tester; core side driven from xorshift values
`timescale 1ns/10ps
`include "jbsp_defs.vh"
module test_jbsp_port;
  reg clk = 1'b0;
  reg reset = 1'b1;
  reg [7:0] pin_in = 8'h00, core_out = 8'h00, core_oe = 8'h00;
  wire tck, tms, tdi, tdo_r, tdo_oe_r;
  wire [7:0] core_in_r, pin_out_r, pin_oe_r;
  wire [2:0] ir_r;
  reg [2:0] o3;
  integer n_mismatch = 0, compares = 0, cyc = 0, i;
  reg [31:0] seed = 32'h2B, q, d, p, h;
  localparam [31:0] ID = {4'h9, 16'hA5C3, 11'h155, `JBSP_ID_FIXED};  // arbitrary values
  always #50 clk = ~clk;
  jbsp_port #(.MFG_CODE(11'h155), .PART_CODE(16'hA5C3), .VER_CODE(4'h9)) i_jbsp_port (.clk(clk),
    .reset(reset), .tck(tck), .tms(tms), .tdi(tdi), .tdo_r(tdo_r), .tdo_oe_r(tdo_oe_r),
    .pin_in(pin_in), .core_in_r(core_in_r), .core_out(core_out), .core_oe(core_oe),
    .pin_out_r(pin_out_r), .pin_oe_r(pin_oe_r), .ir_r(ir_r));
  // released tdo reads the pull-up level
  jbsp_tester i_jbsp_tester (.clk(clk), .tdo(tdo_oe_r ? tdo_r : 1'b1), .tck(tck), .tms(tms),
    .tdi(tdi));
  function [31:0] xs(input dummy);
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      xs = seed;
    end
  endfunction
  task chk(input string nm, input [31:0] e, input [31:0] s);
    begin
      compares = compares + 1;
      if (e !== s)
      begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  // new pin and core values, then a new scan word
  task rnd;
    begin
      @(posedge clk);
      p = xs(0);
      pin_in <= p[7:0];
      core_out <= p[15:8];
      core_oe <= p[23:16];
      d = xs(0);
    end
  endtask
  task wrap_up;
    begin
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // hang guard
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 12000)
    begin
      n_mismatch = n_mismatch + 1;
      wrap_up;
    end
  end
  // main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk("ir reset", 32'h1, ir_r);
    i_jbsp_tester.rst;
    i_jbsp_tester.dr(32'h0, q);
    chk("id word", ID, q);
    chk("tdo off", 32'h0, tdo_oe_r);
    $display("test idcode done");
    rnd;
    i_jbsp_tester.ir(`JBSP_OP_PASS, o3);
    chk("ir capture", `JBSP_IR_CAPT, o3);
    i_jbsp_tester.dr(d, q);
    chk("bypass", {d[30:0], 1'b0}, q);
    $display("test bypass done");
    i_jbsp_tester.ir(`JBSP_OP_SAMPLE, o3);
    i_jbsp_tester.dr(d, q);
    chk("sample capture", {d[15:0], p[15:0]}, q);
    chk("sample pins", p[15:8], pin_out_r);
    h = d;
    i_jbsp_tester.ir(`JBSP_OP_EXT, o3);
    chk("preload pins", h[31:24], pin_out_r);
    rnd;
    i_jbsp_tester.dr(d, q);
    chk("ext capture", {d[15:0], p[7:0]}, {q[31:16], q[7:0]});
    chk("ext pins", d[31:24], pin_out_r);
    $display("test extest done");
    h = d;
    i_jbsp_tester.ir(`JBSP_OP_CLAMP, o3);
    rnd;
    i_jbsp_tester.dr(d, q);
    chk("clamp path", {d[30:0], 1'b0}, q);
    chk("clamp pins", h[31:24], pin_out_r);
    for (i = 4; i < 7; i = i + 2)
    begin
      i_jbsp_tester.ir(i[2:0], o3);
      rnd;
      i_jbsp_tester.dr(d, q);
      chk("other codes", {d[30:0], 1'b0}, q);
      chk("other oe", (i == 4) ? 32'h0 : {24'h0, p[23:16]}, pin_oe_r);
    end
    i_jbsp_tester.ir(`JBSP_OP_EXT, o3);
    i_jbsp_tester.rst;
    chk("ir tms reset", 32'h1, ir_r);
    chk("normal pins", p[15:8], pin_out_r);
    $display("test clamp float reset done");
    wrap_up;
  end
endmodule // test_jbsp_port
